// ===== dv/lpcg_cpu_model.sv
// partner model: processor bus cycles run from the gated clock
`timescale 1ns/1ps
module lpcg_cpu_model
    import lpcg_pkg::*;
(
    // gated clock and reset
    input wire logic cpu_clk_i,
    input wire logic rst_n_i,
    // one access, then a run of fetches
    input wire logic go_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [FC_W-1:0] fc_i,
    input wire logic rd_wr_n_i,
    input wire logic [3:0] nfetch_i,
    // bus as the processor drives it
    output lpcg_bus_s bus_o
);
    logic [4:0] left_r; // bus cycles still to run
    // moves only on processor edges, so all state holds while gated
    always_ff @(posedge cpu_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_r <= 5'h0;
            bus_o <= '{addr: '0, fc: '0, rd_wr_n: 1'b1, as_n: 1'b1};
        end else if (go_i && left_r == 5'h0 && bus_o.as_n) begin
            // access from the handler, then the halt fetches
            left_r <= {1'b0, nfetch_i} + 5'h1;
            bus_o <= '{addr: addr_i, fc: fc_i, rd_wr_n: rd_wr_n_i, as_n: 1'b0};
        end else if (!bus_o.as_n) begin
            // close the cycle
            left_r <= left_r - 5'h1;
            bus_o.as_n <= 1'b1;
        end else if (left_r != 5'h0) begin
            // next program fetch
            bus_o <= '{addr: bus_o.addr + 24'h2, fc: 3'h6, rd_wr_n: 1'b1, as_n: 1'b0};
        end else begin
            // idle bus shows no stale address
            bus_o.addr <= ~bus_o.addr;
        end
    end
endmodule : lpcg_cpu_model

// ===== dv/testbench.sv
// testbench: random and corner bus traffic against the clock gate controller
`timescale 1ns/1ps
module testbench;
    import lpcg_pkg::*;
    localparam logic [ADDR_W-1:0] LPA = 24'h00a5c0; // trigger address under test
    logic ref_clk, rst_n, go, wr_n, b8, stable, restart, flt, prev_as;
    logic [ADDR_W-1:0] addr; // access address
    logic [ADDR_W-1:0] a_try; // candidate trigger address, bench side only
    logic [FC_W-1:0] fc; // access function code
    logic [IPL_W-1:0] irq_lvl, wake;
    logic [3:0] nf; // fetches after the access
    lpcg_bus_s bus;
    logic cpu_clk, bus_req, hit, asleep;
    int error_cnt, checks_done, ends, cpu_edges, cyc, i;
    lpcg_cpu_model cpu (.cpu_clk_i(cpu_clk), .rst_n_i(rst_n), .go_i(go), .addr_i(addr),
        .fc_i(fc), .rd_wr_n_i(wr_n), .nfetch_i(nf), .bus_o(bus));
    lpcg_gate #(.LP_ADDR(LPA), .STABLE_WAIT(1)) dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .bus_i(bus), .bus8_mode_i(b8), .interrupt_level_inputs_i(irq_lvl), .wake_level_i(wake),
        .sys_clk_stable_i(stable), .clock_restart_req_i(restart), .float_en_i(flt),
        .cpu_clk_o(cpu_clk), .bus_request_line_o(bus_req), .low_power_addr_hit_o(hit),
        .asleep_o(asleep));
    // 10 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // count processor edges
    always @(posedge cpu_clk) cpu_edges++;
    // count bus cycle ends and cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (bus.as_n === 1'b1 && prev_as === 1'b0) ends++;
        prev_as = bus.as_n;
        if (cyc > 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    function automatic logic exp_hit(input logic [2:0] f, input logic w, input logic [23:0] a);
        return f == 3'h5 && !w && a == LPA;
    endfunction : exp_hit
    // start one access and its fetches on the model
    task automatic bus_op(input logic [2:0] f, input logic w, input logic [23:0] a,
        input logic [3:0] n);
        @(posedge ref_clk);
        fc <= f;
        wr_n <= w;
        addr <= a;
        nf <= n;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask : bus_op
    // full sleep and wake, both bus widths, with and without floating
    task automatic sleep_run(input logic m8, input logic fl);
        int base;
        int edges;
        int n;
        b8 <= m8;
        flt <= fl;
        wake <= 3'($urandom % 6 + 2);
        base = ends;
        bus_op(3'h5, 1'b0, LPA, 4'h8);
        for (n = 0; n < 60 && asleep !== 1'b1; n++) @(posedge ref_clk);
        check("hit", hit, 1);
        check("ends", ends - base, m8 ? 4 : 3);
        edges = cpu_edges;
        stable <= 1'b0;
        irq_lvl <= wake;
        // an early request is refused while unstable; a late one crosses the synchroniser
        restart <= fl;
        repeat (20) @(posedge ref_clk);
        check("stopped", cpu_edges - edges, 0);
        check("float", bus_req, fl);
        stable <= 1'b1;
        irq_lvl <= wake - 3'h1;
        repeat (20) @(posedge ref_clk);
        check("low level", asleep, 1);
        irq_lvl <= wake;
        restart <= 1'b1;
        for (n = 0; n < 30 && asleep !== 1'b0; n++) @(posedge ref_clk);
        check("woken", asleep, 0);
        check("hit clear", hit, 0);
        check("released", bus_req, 0);
        restart <= 1'b0;
        irq_lvl <= 3'h0;
        repeat (20) @(posedge ref_clk);
        check("resumed", cpu_edges - edges > 15, 1);
        $display("test sleep bus8 %0d float %0d done", m8, fl);
    endtask : sleep_run
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    // main sequence
    initial begin
        {rst_n, go, b8, restart, flt, fc, irq_lvl, wake, nf, addr} = '0;
        {wr_n, stable} = 2'b11;
        {error_cnt, checks_done, ends, cpu_edges, cyc} = '0;
        void'($urandom(32'h6ad4));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // every code and direction at the trigger address, except the supervisor write, which goes to a near miss
        for (i = 0; i < 16; i++) begin
            a_try = (i == 10) ? LPA ^ 24'($urandom_range(255, 1)) : LPA;
            bus_op(3'(i >> 1), i[0], a_try, 4'h0);
            repeat (4) @(posedge ref_clk);
            check("hit", hit, exp_hit(3'(i >> 1), i[0], a_try));
        end
        $display("test refusals done");
        for (i = 0; i < 4; i++) sleep_run(i[0], i[1]);
        // reset while asleep: clock back at once, and a fresh entry counts anew
        bus_op(FC_SUPER_DATA, 1'b0, LPA, 4'h8);
        for (i = 0; i < 60 && asleep !== 1'b1; i++) @(posedge ref_clk);
        check("asleep", asleep, 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("reset wake", asleep, 0);
        check("reset hit", hit, 0);
        check("reset float", bus_req, 0);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        $display("test reset in sleep done");
        sleep_run(1'b0, 1'b0);
        results();
    end
endmodule : testbench

// ===== hw/lpcg_gate.sv
// module: low-power clock gate controller outside a static processor
// Summary of operation
// - entry only from supervisor mode
// - software enters through exception handler
// - trigger address is configurable constant
// - hit on address, write, function code 101
// - count bus cycles from the hit write
// - gate clock after halt operand fetch
// - 8-bit bus waits one extra cycle
// - gated clock shows no runt pulses except at a reset during sleep
// - optional arbitration during status word fetch
// - wake only on interrupt level at or above selected
// - clock stable before restart request
// - restart at next falling system edge
// - release bus request after wake
// - handler writes address then halts
`timescale 1ns/1ps
module lpcg_gate
    import lpcg_pkg::*;
#(
    parameter logic [ADDR_W-1:0] LP_ADDR = LP_ADDR_RST,
    parameter int STABLE_WAIT = STABLE_CYC
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // processor bus
    input wire lpcg_bus_s bus_i,
    input wire logic bus8_mode_i,
    // wake control
    input wire logic [IPL_W-1:0] interrupt_level_inputs_i,
    input wire logic [IPL_W-1:0] wake_level_i,
    input wire logic sys_clk_stable_i,
    input wire logic clock_restart_req_i,
    input wire logic float_en_i,
    // clock and arbitration out
    output logic cpu_clk_o,
    output logic bus_request_line_o,
    output logic low_power_addr_hit_o,
    output logic asleep_o
);
    // refuse a stability wait that the eight-bit wait counter cannot serve
    if (STABLE_WAIT < 1 || STABLE_WAIT > 255) begin : g_bad_wait
        $error("stable wait must be 1 to 255 cycles");
    end
    lpcg_state_e state_r, state_nxt; // sequencer
    logic [2:0] cnt_r, cnt_nxt; // bus cycles since hit
    logic as_d_r; // previous strobe level
    logic gate_en_r; // clock enable, changed on falling edge
    logic hit_r; // address hit seen
    logic br_r; // bus request held
    logic [7:0] stab_r; // stability wait
    logic restart_s; // synchronised restart
    logic rst_s; // synchronised reset release
    // last halt fetch cycle: the counter is about to reach its mark
    function automatic logic op_done(input logic [2:0] cnt, input logic [2:0] last);
        return (cnt + 3'h1) == last;
    endfunction : op_done
    // synchronise restart and reset
    lpcg_sync u_sync_rst (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(1'b1),
        .q_o(rst_s)
    );
    lpcg_sync u_sync_rs (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(clock_restart_req_i),
        .q_o(restart_s)
    );
    // address hit decode: the handler's supervisor byte write
    wire hit_now = (bus_i.addr == LP_ADDR) && !bus_i.rd_wr_n
        && (bus_i.fc == FC_SUPER_DATA) && !bus_i.as_n;
    wire cyc_end = bus_i.as_n && !as_d_r; // strobe negation ends a cycle
    wire [2:0] cyc_last = bus8_mode_i ? CYC_8 : CYC_16;
    wire irq_ok = (interrupt_level_inputs_i >= wake_level_i)
        && (interrupt_level_inputs_i != 3'h0);
    wire stab_done = (stab_r >= 8'(STABLE_WAIT));
    // clock stays off from sleep until the sequencer is back in run
    wire clk_off = (state_r == ST_SLEEP) || (state_r == ST_WAKE) || (state_r == ST_RELEASE);
    // next-state logic
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            // running: wait for the trigger write
            ST_RUN: begin
                cnt_nxt = CNT_RST;
                if (hit_now) state_nxt = ST_COUNT;
            end
            // counting the write and the halt fetch cycles
            ST_COUNT: begin
                if (cyc_end) cnt_nxt = cnt_r + 3'h1;
                if (cyc_end && op_done(cnt_r, cyc_last)) state_nxt = ST_SLEEP;
            end
            // clock off: wait for a wake level on a stable clock
            ST_SLEEP: begin
                if (irq_ok && sys_clk_stable_i) state_nxt = ST_WAKE;
            end
            // wait for the synchronised restart and the stability count
            ST_WAKE: begin
                if (restart_s && stab_done) state_nxt = ST_RELEASE;
            end
            // one cycle to drop the bus request before the clock returns
            ST_RELEASE: begin
                cnt_nxt = CNT_RST;
                state_nxt = ST_RUN;
            end
        endcase
    end
    // sequencer registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_RUN;
            cnt_r <= CNT_RST;
            as_d_r <= 1'b1;
        end else if (!rst_s) begin
            state_r <= ST_RUN;
            cnt_r <= CNT_RST;
            as_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            as_d_r <= bus_i.as_n;
        end
    end
    // hit flag, cleared on restart
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) hit_r <= 1'b0;
        else if (hit_now) hit_r <= 1'b1;
        else if (state_r == ST_RELEASE || !rst_s) hit_r <= 1'b0;
    end
    // stability counter in wake state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) stab_r <= 8'h0;
        else if (state_r != ST_WAKE) stab_r <= 8'h0;
        else if (!stab_done) stab_r <= stab_r + 8'h1;
    end
    // bus request: raised on status word fetch, dropped on wake
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) br_r <= 1'b0;
        else if (state_r == ST_COUNT && cnt_r == SW_CYC_16 && float_en_i) br_r <= 1'b1;
        else if (state_r == ST_RELEASE) br_r <= 1'b0;
    end
    // enable changes on falling edge while clock low, so no runt; a reset sets it at once
    always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) gate_en_r <= 1'b1;
        else gate_en_r <= !clk_off;
    end
    assign cpu_clk_o = ref_clk_i & gate_en_r;
    assign bus_request_line_o = br_r;
    assign low_power_addr_hit_o = hit_r;
    assign asleep_o = !gate_en_r;
    // a qualifying write is remembered from the next edge on
    a_hit_decode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hit_now |=> hit_r) else $error("hit not latched");
    // the flag stays set until the restart or a reset clears it
    a_hit_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (hit_r && state_r != ST_RELEASE && rst_s) |=> hit_r) else $error("hit lost");
    // a read or any other function code never raises the flag
    a_user_no_hit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!hit_r && (bus_i.fc != FC_SUPER_DATA || bus_i.rd_wr_n)) |=> !hit_r)
        else $error("hit without supervisor write");
    // the counter never runs past its mark while counting
    a_cnt_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_COUNT) |-> cnt_r < cyc_last) else $error("count overran");
    // the last operand cycle end sends the sequencer to sleep
    a_sleep_after: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_COUNT && cyc_end && op_done(cnt_r, cyc_last) && rst_s)
        |=> state_r == ST_SLEEP) else $error("no sleep after operand");
    // an eight-bit bus needs its fourth cycle end before sleeping
    a_eight_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_COUNT && bus8_mode_i && cnt_r < 3'h3) |=> state_r != ST_SLEEP)
        else $error("8-bit slept early");
    // one edge into sleep the enable has dropped
    a_gate_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_SLEEP) ##1 (state_r == ST_SLEEP) |-> !gate_en_r)
        else $error("clock not gated");
    // a level of zero or below the wake level keeps it asleep
    a_wake_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_SLEEP && (interrupt_level_inputs_i == 3'h0
        || interrupt_level_inputs_i < wake_level_i)) |=> state_r != ST_WAKE)
        else $error("woke without interrupt");
    // restart waits for the stability count
    a_wake_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_WAKE && !stab_done) |=> state_r != ST_RELEASE)
        else $error("restart before stable");
    // a request that has not passed both synchroniser stages is not acted on
    a_restart_sync: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_WAKE && !$past(clock_restart_req_i, 2)) |=> state_r != ST_RELEASE)
        else $error("restart used unsynchronised");
    // a float request is raised during the status word fetch
    a_br_raise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_COUNT && cnt_r == SW_CYC_16 && float_en_i) |=> br_r)
        else $error("bus request not raised");
    // the bus request is gone before the clock comes back
    a_br_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_RELEASE) |=> !br_r) else $error("bus request held");
    // the clock stays off through the release cycle
    a_rel_clk_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_RELEASE) |-> !gate_en_r) else $error("clock back before release");
    // a restart leaves count and flag clear for the next entry
    a_clear_cnt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_RELEASE && rst_s && !hit_now) |=> cnt_r == CNT_RST && !hit_r)
        else $error("state not cleared");
    // the clock runs freely while the sequencer is in run
    a_clk_on: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_RUN) ##1 (state_r == ST_RUN) |-> gate_en_r)
        else $error("clock gated while running");
    // main scenarios: sleep, synchronised restart, release, float and eight-bit entry
    c_sleep: cover property (@(posedge ref_clk_i) state_r == ST_SLEEP);
    c_restart: cover property (@(posedge ref_clk_i) state_r == ST_WAKE && restart_s);
    c_wake: cover property (@(posedge ref_clk_i) state_r == ST_RELEASE);
    c_float: cover property (@(posedge ref_clk_i) br_r);
    c_eight: cover property (@(posedge ref_clk_i) bus8_mode_i && state_r == ST_SLEEP);
endmodule : lpcg_gate

// ===== hw/lpcg_sync.sv
// module: two flip-flop synchroniser
`timescale 1ns/1ps
module lpcg_sync
    import lpcg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_r; // first stage, read only by second
    logic q_r; // second stage
    // shift the level through two stages
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule : lpcg_sync

// ===== pkg/lpcg_pkg.sv
// package: constants and carriers for the low-power clock gate controller
package lpcg_pkg;
    localparam int ADDR_W = 24;
    localparam int FC_W = 3;
    localparam int IPL_W = 3;
    localparam logic [2:0] FC_SUPER_DATA = 3'h5;
    localparam logic [ADDR_W-1:0] LP_ADDR_RST = 24'hfffff0;
    // halt fetch: write cycle, opcode fetch, operand fetch(es)
    localparam logic [2:0] CYC_16 = 3'h3;
    localparam logic [2:0] CYC_8 = 3'h4;
    localparam logic [2:0] SW_CYC_16 = 3'h2;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam int STABLE_NS = 1000;
    localparam int CLK_NS = 100;
    localparam int STABLE_CYC = (STABLE_NS + CLK_NS - 1) / CLK_NS;
    // processor bus as seen by the controller
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [FC_W-1:0] fc;
        logic rd_wr_n;
        logic as_n;
    } lpcg_bus_s;
    typedef enum logic [2:0] {ST_RUN, ST_COUNT, ST_SLEEP, ST_WAKE, ST_RELEASE} lpcg_state_e;
endpackage : lpcg_pkg
